// ---- host_port_device.sv ----
// Purpose: Device end of the control port: serial, direction-strobe and
//          split-strobe register access onto a user register port.
// Assumes: Runs on the link clock; host pins are asynchronous to it.
//          regRdData follows regAddr combinationally in the user logic.
// Notes:   Pins are seen two link clocks late; host strobes must be
//          several link clocks wide.
`timescale 1ns/1ns

// Contract
// - Direction mode latches address on strobe fall
// - Serial input sampled on shift clock rise
// - Host starts split write with write low
// - Split mode takes write data from bus
// - Host holds direction low write, high read
// - Serial output edge chosen by edge select
// - Host samples serial output on opposite edge
// - Acknowledge low when read valid or written
// - Ready low during access, high when done
// - Split mode drives bus while read low
// - Direction mode captures or drives by direction
// - Same eight lines carry address then data
// - Accesses accepted only with chip select low
// - Split mode latches address on latch fall
module host_port_device (
   input  wire logic                                linkClk,
   input  wire logic                                resetn,
   host_port_if.device                              port,
   output logic [host_port_pkg::ADDR_W-1:0]         regAddr,
   output logic [host_port_pkg::DATA_W-1:0]         regWrData,
   output logic                                     regWrite,
   output logic                                     regRead,
   input  wire logic [host_port_pkg::DATA_W-1:0]    regRdData
);
   typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_READ, ST_HOLD} par_t;

   logic [18:0]                 rawIn;
   logic [18:0]                 syncIn;
   logic [8:0]                  ctl;
   logic [8:0]                  ctlPrev;
   logic [7:0]                  adS;
   host_port_pkg::access_mode_t mode;
   logic                        csS;
   logic                        sclkS;
   logic                        sdiS;
   logic                        edgeS;
   logic                        alS;
   logic                        dsS;
   logic                        rwS;
   logic                        rdS;
   logic                        wrS;
   logic                        sel;
   logic                        isSer;
   logic                        isDir;
   logic                        isSplit;
   logic                        isPar;
   logic                        sclkRise;
   logic                        sclkFall;
   logic                        outEdge;
   logic                        alFall;
   logic                        strobeFall;
   logic                        strobeEnd;
   logic                        parWrite;
   par_t                        pstate;
   par_t                        next_pstate;
   logic                        drive;
   logic [7:0]                  adOut;
   logic [4:0]                  bitCnt;
   logic [7:0]                  rxShift;
   logic                        serRead;
   logic [7:0]                  serByte;
   logic                        serAddrDone;
   logic                        serRdPulse;
   logic                        serWrPulse;
   logic                        loadPend;
   logic                        txValid;
   logic [7:0]                  txShift;
   logic                        sdoBit;
   logic                        sdoOe;

   // All host pins, the mode strap included, cross into the link domain
   assign rawIn = {port.accessMode, port.adBus, port.csN, port.shiftClk,
                   port.hostSerialIn, port.outEdgeSelect,
                   port.addrLatchStrobeM, port.dirstrobeDataStrobeN,
                   port.rwSelect, port.readStrobeN, port.writeStrobeN};

   sync2 #(
      .W    (19),
      .INIT ({10'h000, host_port_pkg::DEV_CTL_IDLE})
   ) inSync (
      .clk    (linkClk),
      .resetn (resetn),
      .d      (rawIn),
      .q      (syncIn)
   );

   // Field split of the synchronised pins
   assign mode  = host_port_pkg::access_mode_t'(syncIn[18:17]);
   assign adS   = syncIn[16:9];
   assign ctl   = syncIn[8:0];
   assign csS   = ctl[8];
   assign sclkS = ctl[7];
   assign sdiS  = ctl[6];
   assign edgeS = ctl[5];
   assign alS   = ctl[4];
   assign dsS   = ctl[3];
   assign rwS   = ctl[2];
   assign rdS   = ctl[1];
   assign wrS   = ctl[0];

   // Previous pin levels for edge detection
   always_ff @(posedge linkClk) begin
      if (!resetn) ctlPrev <= host_port_pkg::DEV_CTL_IDLE;
      else         ctlPrev <= ctl;
   end

   // Mode decode and qualified pin edges; nothing counts while deselected
   assign sel     = !csS;
   assign isSer   = mode == host_port_pkg::MODE_SERIAL;
   assign isDir   = mode == host_port_pkg::MODE_DIRSTROBE;
   assign isSplit = mode == host_port_pkg::MODE_SPLIT;
   assign isPar   = isDir | isSplit;
   assign sclkRise = sel & isSer & sclkS & !ctlPrev[7];
   assign sclkFall = sel & isSer & !sclkS & ctlPrev[7];
   assign outEdge  = edgeS ? sclkFall : sclkRise;
   // Address strobe and address latch enable share one pin
   assign alFall   = sel & isPar & !alS & ctlPrev[4];
   assign strobeFall = sel & (isDir ? (!dsS & ctlPrev[3]) :
                       isSplit & ((!rdS & ctlPrev[1]) | (!wrS & ctlPrev[0])));
   assign strobeEnd = isDir ? dsS : (rdS & wrS);
   // Direction pin low means write; in split mode the write strobe says
   assign parWrite = isDir ? !rwS : !wrS;

   // Parallel access sequence, shared by both strobe styles
   always_comb begin
      next_pstate = pstate;
      if (!sel || !isPar) begin
         next_pstate = ST_IDLE;
      end else begin
         unique case (pstate)
            ST_IDLE:  if (strobeFall)
                         next_pstate = parWrite ? ST_WRITE : ST_READ;
            ST_WRITE: next_pstate = ST_HOLD;
            ST_READ:  next_pstate = ST_HOLD;
            ST_HOLD:  if (strobeEnd) next_pstate = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge linkClk) begin
      if (!resetn) pstate <= ST_IDLE;
      else         pstate <= next_pstate;
   end

   // Serial frame decode on the synchronised shift clock
   assign serByte     = {rxShift[6:0], sdiS};
   assign serAddrDone = sclkRise & (bitCnt == host_port_pkg::SER_ADDR_LAST);
   assign serRdPulse  = serAddrDone & serRead;
   assign serWrPulse  = sclkRise & !serRead &
                        (bitCnt == host_port_pkg::SER_LAST);

   // Input shift on every rise whatever the output edge; frame restarts
   // whenever chip select goes high
   always_ff @(posedge linkClk) begin
      if (!resetn || !sel) begin
         bitCnt  <= 5'h00;
         rxShift <= 8'h00;
         serRead <= 1'h0;
      end else if (sclkRise) begin
         rxShift <= serByte;
         if (bitCnt <= host_port_pkg::SER_LAST) bitCnt <= bitCnt + 5'h01;
         if (bitCnt == 5'h00) serRead <= sdiS;
      end
   end

   // Read data is loaded one cycle after the address so that the user
   // read mux has settled on the new address
   always_ff @(posedge linkClk) begin
      if (!resetn || !sel) begin
         loadPend <= 1'h0;
         txValid  <= 1'h0;
         txShift  <= 8'h00;
         sdoBit   <= 1'h0;
         sdoOe    <= 1'h0;
      end else if (serRdPulse) begin
         loadPend <= 1'h1;
      end else if (loadPend) begin
         loadPend <= 1'h0;
         txShift  <= regRdData;
         txValid  <= 1'h1;
      end else if (outEdge && txValid) begin
         sdoBit  <= txShift[7];
         txShift <= {txShift[6:0], 1'h0};
         sdoOe   <= 1'h1;
      end
   end

   // User register port: address from latch strobe or serial header
   always_ff @(posedge linkClk) begin
      if (!resetn) begin
         regAddr   <= 8'h00;
         regWrData <= 8'h00;
         regWrite  <= 1'h0;
         regRead   <= 1'h0;
      end else begin
         regWrite <= (pstate == ST_WRITE) | serWrPulse;
         regRead  <= (strobeFall & !parWrite & pstate == ST_IDLE) |
                     serRdPulse;
         if (alFall)           regAddr <= adS;
         else if (serAddrDone) regAddr <= serByte;
         if (pstate == ST_WRITE) regWrData <= adS;
         else if (serWrPulse)    regWrData <= serByte;
      end
   end

   // Parallel read data register and its drive flag
   always_ff @(posedge linkClk) begin
      if (!resetn) begin
         adOut <= 8'h00;
         drive <= 1'h0;
      end else if (pstate == ST_READ) begin
         adOut <= regRdData;
         drive <= 1'h1;
      end else if (next_pstate == ST_IDLE) begin
         drive <= 1'h0;
      end
   end

   // Bus is driven only while the read strobe, or in direction mode the data strobe with direction high, is still low
   assign port.adDev   = adOut;
   assign port.adDevOe = drive & sel & (isDir ? (!dsS & rwS) :
                         isSplit & !rdS);
   assign port.hostSerialOut   = sdoBit;
   assign port.hostSerialOutOe = sdoOe & sel & isSer;

   // Handshakes: acknowledge low until strobe returns, ready low while busy
   assign port.ackN  = !(sel & isDir & pstate == ST_HOLD);
   assign port.ready = !(sel & isSplit &
                       (pstate == ST_WRITE | pstate == ST_READ));
endmodule // host_port_device

// ---- host_port_pkg.sv ----
// Purpose: Shared constants and types for the host control port.
// Assumes: Eight-bit register address and data on every access kind.
// Notes:   Host timing counts derive from the host clock period.
package host_port_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   // Serial frame: read flag, address, data, MSB first
   localparam logic [4:0] SER_ADDR_LAST = 5'h08;
   localparam logic [4:0] SER_LAST      = 5'h10;
   localparam logic [4:0] SER_DATA_FIRST = 5'h09;
   // Idle levels of synchronised pins, used as their reset values
   localparam logic [8:0]  DEV_CTL_IDLE  = 9'h10F;
   localparam logic [10:0] HOST_IN_IDLE  = 11'h300;
   // Host strobe step and shift clock half period
   localparam int CLK_NS   = 100;
   localparam int STEP_NS  = 800;
   localparam int STEP_CYC = (STEP_NS + CLK_NS - 1) / CLK_NS;
   typedef enum logic [1:0] {
      MODE_SERIAL,
      MODE_DIRSTROBE,
      MODE_SPLIT
   } access_mode_t;
endpackage

// ---- host_port_if.sv ----
// Purpose: Pin bundle between the host and the line unit control port.
// Assumes: Shared address/data lines have a weak pull-down.
// Notes:   Resolves the shared bus and serial output from the enables.
`timescale 1ns/1ns
interface host_port_if;
   logic                      csN;
   logic                      shiftClk;
   logic                      hostSerialIn;
   logic                      outEdgeSelect;
   logic                      addrLatchStrobeM;
   logic                      dirstrobeDataStrobeN;
   logic                      rwSelect;
   logic                      readStrobeN;
   logic                      writeStrobeN;
   logic [7:0]                adHost;
   logic                      adHostOe;
   logic                      hostSerialOut;
   logic                      hostSerialOutOe;
   logic                      ackN;
   logic                      ready;
   logic [7:0]                adDev;
   logic                      adDevOe;
   host_port_pkg::access_mode_t accessMode;
   logic [7:0]                adBus;
   logic                      serialLine;

   // Same eight lines carry address then data; pull-down when undriven
   assign adBus = adDevOe ? adDev : (adHostOe ? adHost : 8'h00);
   assign serialLine = hostSerialOutOe ? hostSerialOut : 1'h0;

   modport device (
      input  csN, shiftClk, hostSerialIn, outEdgeSelect, addrLatchStrobeM,
      input  dirstrobeDataStrobeN, rwSelect, readStrobeN, writeStrobeN,
      input  adBus, accessMode,
      output hostSerialOut, hostSerialOutOe, ackN, ready, adDev, adDevOe
   );
   modport host (
      output csN, shiftClk, hostSerialIn, outEdgeSelect, addrLatchStrobeM,
      output dirstrobeDataStrobeN, rwSelect, readStrobeN, writeStrobeN,
      output adHost, adHostOe, accessMode,
      input  serialLine, ackN, ready, adBus
   );
endinterface // host_port_if

// ---- sync2.sv ----
// Purpose: Two-stage synchroniser for pins from a foreign clock.
// Assumes: Each bit is a level; buses are held stable while sampled.
// Notes:   Reset value is the pin idle level so no false edge appears.
`timescale 1ns/1ns
module sync2 #(
   parameter int           W    = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input  wire logic         clk,
   input  wire logic         resetn,
   input  wire logic [W-1:0] d,
   output logic [W-1:0]      q
);
   logic [W-1:0] meta;

   // First stage feeds only the second stage
   always_ff @(posedge clk) begin
      if (!resetn) begin
         meta <= INIT;
         q    <= INIT;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule // sync2

// ---- host_port_host.sv ----
// Purpose: Host end: runs one register access at a time in any mode.
// Assumes: Device returns handshakes within one step of a strobe edge.
// Notes:   Every pin phase lasts STEP host clocks; shift clock too.
`timescale 1ns/1ns
module host_port_host #(
   parameter int STEP = host_port_pkg::STEP_CYC
) (
   input  wire logic                                clk,
   input  wire logic                                resetn,
   host_port_if.host                                port,
   input  wire host_port_pkg::access_mode_t         mode,
   input  wire logic                                edgeSelect,
   input  wire logic                                start,
   input  wire logic                                readReq,
   input  wire logic [host_port_pkg::ADDR_W-1:0]    addr,
   input  wire logic [host_port_pkg::DATA_W-1:0]    wrData,
   output logic                                     busy,
   output logic                                     done,
   output logic [host_port_pkg::DATA_W-1:0]         rdData
);
   typedef enum logic [2:0] {
      H_IDLE, H_SER_LOW, H_SER_HIGH, H_ADDR, H_LATCH, H_STROBE, H_WAIT, H_END
   } host_t;
   localparam logic [7:0] STEP_LAST = 8'(STEP - 1);

   host_t                       state;
   logic [7:0]                  tmr;
   logic                        tmrDone;
   logic [4:0]                  bitIdx;
   logic [16:0]                 frame;
   logic                        isRd;
   host_port_pkg::access_mode_t curMode;
   logic                        edgeReg;
   logic [10:0]                 syncIn;
   logic                        sdoS;
   logic                        ackS;
   logic                        readyS;
   logic [7:0]                  adS;
   logic                        dataLate;
   logic                        handDone;
   logic                        csN;
   logic                        sclk;
   logic                        host_serial_in;
   logic                        al;
   logic                        dsN;
   logic                        rw;
   logic                        rdN;
   logic                        wrN;
   logic [7:0]                  adOut;
   logic                        adOe;

   sync2 #(
      .W    (11),
      .INIT (host_port_pkg::HOST_IN_IDLE)
   ) inSync (
      .clk    (clk),
      .resetn (resetn),
      .d      ({port.serialLine, port.ackN, port.ready, port.adBus}),
      .q      (syncIn)
   );

   // Decode of synchronised device outputs and step timing
   assign sdoS     = syncIn[10];
   assign ackS     = syncIn[9];
   assign readyS   = syncIn[8];
   assign adS      = syncIn[7:0];
   assign tmrDone  = tmr == STEP_LAST;
   assign dataLate = isRd & (bitIdx >= host_port_pkg::SER_DATA_FIRST);
   assign handDone = tmrDone & ((curMode == host_port_pkg::MODE_DIRSTROBE)
                     ? !ackS : readyS);
   assign busy     = state != H_IDLE;

   // Pins come straight from flops
   assign port.csN                  = csN;
   assign port.shiftClk             = sclk;
   assign port.hostSerialIn         = host_serial_in;
   assign port.outEdgeSelect        = edgeReg;
   assign port.addrLatchStrobeM     = al;
   assign port.dirstrobeDataStrobeN = dsN;
   assign port.rwSelect             = rw;
   assign port.readStrobeN          = rdN;
   assign port.writeStrobeN         = wrN;
   assign port.adHost               = adOut;
   assign port.adHostOe             = adOe;
   assign port.accessMode           = curMode;

   // One access per start; mode and edge strap only change while idle
   always_ff @(posedge clk) begin
      if (!resetn) begin
         state <= H_IDLE;
         tmr <= 8'h00;
         bitIdx <= 5'h00;
         frame <= 17'h00000;
         isRd <= 1'h0;
         curMode <= host_port_pkg::MODE_SERIAL;
         edgeReg <= 1'h0;
         csN <= 1'h1;
         sclk <= 1'h0;
         host_serial_in <= 1'h0;
         al <= 1'h0;
         dsN <= 1'h1;
         rw <= 1'h1;
         rdN <= 1'h1;
         wrN <= 1'h1;
         adOut <= 8'h00;
         adOe <= 1'h0;
         rdData <= 8'h00;
         done <= 1'h0;
      end else begin
         done <= 1'h0;
         if (!tmrDone) tmr <= tmr + 8'h01;
         unique case (state)
            H_IDLE: begin
               curMode <= mode;
               edgeReg <= edgeSelect;
               if (start) begin
                  csN   <= 1'h0;
                  isRd  <= readReq;
                  frame <= {readReq, addr, wrData};
                  host_serial_in   <= readReq;
                  bitIdx <= 5'h00;
                  tmr   <= 8'h00;
                  if (mode == host_port_pkg::MODE_SERIAL) begin
                     state <= H_SER_LOW;
                  end else begin
                     al    <= 1'h1;
                     adOut <= addr;
                     adOe  <= 1'h1;
                     state <= H_ADDR;
                  end
               end
            end
            H_SER_LOW: if (tmrDone) begin
               if (dataLate && edgeReg) rdData <= {rdData[6:0], sdoS};
               sclk  <= 1'h1;
               tmr   <= 8'h00;
               state <= H_SER_HIGH;
            end
            H_SER_HIGH: if (tmrDone) begin
               if (dataLate && !edgeReg) rdData <= {rdData[6:0], sdoS};
               sclk <= 1'h0;
               tmr  <= 8'h00;
               if (bitIdx == host_port_pkg::SER_LAST) begin
                  state <= H_END;
               end else begin
                  bitIdx <= bitIdx + 5'h01;
                  frame  <= {frame[15:0], 1'h0};
                  host_serial_in    <= frame[15];
                  state  <= H_SER_LOW;
               end
            end
            H_ADDR: if (tmrDone) begin
               al    <= 1'h0;
               tmr   <= 8'h00;
               state <= H_LATCH;
            end
            H_LATCH: if (tmrDone) begin
               rw    <= isRd;
               adOut <= frame[7:0];
               adOe  <= !isRd;
               tmr   <= 8'h00;
               state <= H_STROBE;
            end
            H_STROBE: if (tmrDone) begin
               if (curMode == host_port_pkg::MODE_DIRSTROBE) dsN <= 1'h0;
               else if (isRd) rdN <= 1'h0;
               else wrN <= 1'h0;
               tmr   <= 8'h00;
               state <= H_WAIT;
            end
            H_WAIT: if (handDone) begin
               if (isRd) rdData <= adS;
               dsN   <= 1'h1;
               rdN   <= 1'h1;
               wrN   <= 1'h1;
               adOe  <= 1'h0;
               tmr   <= 8'h00;
               state <= H_END;
            end
            H_END: if (tmrDone) begin
               csN   <= 1'h1;
               rw    <= 1'h1;
               done  <= 1'h1;
               state <= H_IDLE;
            end
         endcase
      end
   end
endmodule // host_port_host

// ---- host_port_checker.sv ----
// Purpose: Link-side assertions on the control port pins.
// Assumes: Pins reach the device logic about two link clocks late.
// Notes:   Four-cycle spans cover that delay; shorter would false-fire.
`timescale 1ns/1ns
module host_port_checker (
   input wire logic                        linkClk,
   input wire logic                        resetn,
   input wire logic                        csN,
   input wire logic                        shiftClk,
   input wire logic                        outEdgeSelect,
   input wire logic                        dirstrobeDataStrobeN,
   input wire logic                        rwSelect,
   input wire logic                        readStrobeN,
   input wire logic                        hostSerialOut,
   input wire logic                        hostSerialOutOe,
   input wire logic                        ackN,
   input wire logic                        ready,
   input wire logic                        adDevOe,
   input wire host_port_pkg::access_mode_t accessMode
);
   default clocking cb @(posedge linkClk); endclocking
   default disable iff (!resetn);
   // Quiet spans on the host pins
   sequence deselected; csN[*4]; endsequence
   sequence dsIdle; dirstrobeDataStrobeN[*4]; endsequence
   sequence splitNoRead;
      (accessMode != host_port_pkg::MODE_DIRSTROBE && readStrobeN)[*4];
   endsequence
   sequence dirNoRead;
      (accessMode != host_port_pkg::MODE_SPLIT
       && (dirstrobeDataStrobeN || !rwSelect))[*4];
   endsequence
   a_cs_release: assert property (
      deselected |-> !adDevOe && !hostSerialOutOe)
      else $error("Outputs driven while deselected");
   a_split_drive: assert property (
      splitNoRead |-> !adDevOe) else $error("Bus driven without read");
   a_dir_drive: assert property (
      dirNoRead |-> !adDevOe) else $error("Bus driven without read");
   a_ack_idle: assert property (
      dsIdle |-> ackN) else $error("Acknowledge low without strobe");
   a_ack_read: assert property (
      $fell(ackN) && rwSelect |-> adDevOe)
      else $error("Acknowledge before read data");
   a_ready_pulse: assert property (
      !ready |=> ready) else $error("Ready held low too long");
   a_serial_edge: assert property (
      hostSerialOutOe && $changed(hostSerialOut)
      |-> shiftClk == !outEdgeSelect) else $error("Serial out wrong edge");
   a_serial_mode: assert property (
      (accessMode != host_port_pkg::MODE_SERIAL)[*4] |-> !hostSerialOutOe)
      else $error("Serial out active in parallel mode");
endmodule // host_port_checker

// ---- host_control_port_test.sv ----
// Purpose: Bench joining host and device ends of the control port.
// Assumes: User register data is the address XOR 5A.
// Notes:   Checks user sides and the wire captured at strobe edges.
`timescale 1ns/1ns
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
   $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module host_control_port_test;
   logic        clk = 0, linkClk = 0, resetn = 0, linkResetn = 0;
   logic        edgeSelect = 0, start = 0, readReq = 0;
   logic        busy, done, regWrite, regRead;
   logic [7:0]  addr = 8'h00, wrData = 8'h00, rdData, regAddr, regWrData;
   logic [7:0]  wA, wD, latA, latD;
   logic [16:0] sBits;
   int          checks = 0, mismatches = 0, nWr = 0, nRd = 0;
   host_port_pkg::access_mode_t mode = host_port_pkg::MODE_SERIAL;
   wire  [7:0]  regRdData = regAddr ^ 8'h5A;
   host_port_if ifc ();
   host_port_host u_host_port_host (.clk(clk), .resetn(resetn), .port(ifc),
      .mode(mode), .edgeSelect(edgeSelect), .start(start),
      .readReq(readReq), .addr(addr), .wrData(wrData), .busy(busy),
      .done(done), .rdData(rdData));
   host_port_device u_host_port_device (.linkClk(linkClk),
      .resetn(linkResetn), .port(ifc), .regAddr(regAddr),
      .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
      .regRdData(regRdData));
   host_port_checker u_host_port_checker (.linkClk(linkClk),
      .resetn(linkResetn), .csN(ifc.csN), .shiftClk(ifc.shiftClk),
      .outEdgeSelect(ifc.outEdgeSelect),
      .dirstrobeDataStrobeN(ifc.dirstrobeDataStrobeN),
      .rwSelect(ifc.rwSelect), .readStrobeN(ifc.readStrobeN),
      .hostSerialOut(ifc.hostSerialOut),
      .hostSerialOutOe(ifc.hostSerialOutOe), .ackN(ifc.ackN),
      .ready(ifc.ready), .adDevOe(ifc.adDevOe),
      .accessMode(ifc.accessMode));
   // Clocks; link clock offset so the phases never line up
   initial forever #50 clk = ~clk;
   initial begin
      #7;
      forever #24 linkClk = ~linkClk;
   end
   // Record user-side writes and wire values at strobe edges
   always @(posedge linkClk) if (regWrite) begin
      wA <= regAddr;
      wD <= regWrData;
      nWr <= nWr + 1;
   end
   // User-side read pulses, one per read access expected
   always @(posedge linkClk) if (regRead) nRd <= nRd + 1;
   always @(negedge ifc.addrLatchStrobeM) latA = ifc.adBus;
   always @(negedge ifc.writeStrobeN or negedge ifc.dirstrobeDataStrobeN)
      latD = ifc.adBus;
   always @(posedge ifc.shiftClk) if (!ifc.csN)
      sBits = {sBits[15:0], ifc.hostSerialIn};
   // One whole access; bounded wait for done
   task automatic acc(input host_port_pkg::access_mode_t m,
                      input logic e, rd, input logic [7:0] a, d);
      int n = 0;
      @(posedge clk);
      mode <= m;
      edgeSelect <= e;
      readReq <= rd;
      addr <= a;
      wrData <= d;
      repeat (4) @(posedge clk);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      while (done !== 1'b1 && n < 400) begin
         @(posedge clk);
         n++;
      end
      if (n >= 400) mismatches++;
      repeat (2) @(posedge clk);
   endtask
   task automatic serial_scn(input logic e);
      int w = nWr;
      acc(host_port_pkg::MODE_SERIAL, e, 1'b0, 8'hC3, 8'h81);
      `CHK(sBits, {1'b0, 8'hC3, 8'h81})
      `CHK({wA, wD}, 16'hC381)
      acc(host_port_pkg::MODE_SERIAL, e, 1'b1, 8'h3C, 8'h00);
      `CHK(rdData, 8'h66)
      `CHK(nWr - w, 1)
      $display("serial scenario, edge select %0d, finished", e);
   endtask
   task automatic dir_scn();
      int r = nRd;
      acc(host_port_pkg::MODE_DIRSTROBE, 1'b0, 1'b0, 8'h00, 8'hFF);
      `CHK({latA, latD}, 16'h00FF)
      `CHK({wA, wD}, 16'h00FF)
      acc(host_port_pkg::MODE_DIRSTROBE, 1'b0, 1'b1, 8'hFF, 8'h00);
      `CHK(latA, 8'hFF)
      `CHK(rdData, 8'hA5)
      `CHK(nRd - r, 1)
      `CHK(busy, 1'b0)
      $display("direction-strobe scenario finished");
   endtask
   task automatic split_scn();
      int w = nWr;
      acc(host_port_pkg::MODE_SPLIT, 1'b0, 1'b0, 8'h5A, 8'h3C);
      `CHK({latA, latD, wA, wD}, 32'h5A3C5A3C)
      acc(host_port_pkg::MODE_SPLIT, 1'b0, 1'b1, 8'h96, 8'h00);
      `CHK(rdData, 8'hCC)
      `CHK(nWr - w, 1)
      $display("split-strobe scenario finished");
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Main sequence: device leaves reset before the host
   initial begin
      repeat (20) @(posedge clk);
      @(posedge linkClk);
      linkResetn <= 1'b1;
      @(posedge clk);
      resetn <= 1'b1;
      serial_scn(1'b1);
      serial_scn(1'b0);
      dir_scn();
      split_scn();
      conclude();
   end
   // Watchdog, about three times the expected run
   initial begin
      #400000;
      mismatches++;
      conclude();
   end
endmodule // host_control_port_test
